// *** hw/mcx_pkg.sv ***
// Package of constants and types for the misc instruction executor
package mcx_pkg;
  localparam int unsigned MCX_DW = 16;
  localparam int unsigned MCX_PCW = 10;
  localparam int unsigned MCX_ROWS = 5;
  localparam int unsigned MCX_NREG = 8;
  // Opcode patterns, compared on the bits each mask keeps (the whole word for MCX_OP_WRSPI)
  localparam logic [15:0] MCX_OP_TOINT = 16'h3720;
  localparam logic [15:0] MCX_MSK_TOINT = 16'hfff0;
  localparam logic [15:0] MCX_OP_WAIT = 16'h3500;
  localparam logic [15:0] MCX_MSK_WAIT = 16'hffe0;
  localparam logic [15:0] MCX_OP_WRSPI = 16'h3543;
  localparam logic [15:0] MCX_MSK_WRSPI = 16'hffff;
  localparam logic [15:0] MCX_OP_XOR = 16'h2ed0;
  localparam logic [15:0] MCX_MSK_XOR = 16'hfff8;
  localparam logic [15:0] MCX_OP_CWER = 16'h3600;
  localparam logic [15:0] MCX_OP_CWEF = 16'h3680;
  localparam logic [15:0] MCX_MSK_CWE = 16'hff80;
  // Field positions
  localparam int unsigned MCX_RST_BIT = 3;
  localparam int unsigned MCX_CWE_ROW_LSB = 4;
  // Reset values
  localparam logic MCX_CS_RST = 1'b0;
  localparam logic [15:0] MCX_REG_RST = 16'h0000;
  localparam logic [9:0] MCX_PC_RST = 10'h000;
  // Backdoor write takes two core cycles
  localparam int unsigned MCX_WR_NS = 200;
  localparam int unsigned MCX_CLK_NS = 100;
  localparam logic [1:0] MCX_WR_CYC = 2'(MCX_WR_NS / MCX_CLK_NS);
  localparam logic [15:0] MCX_ALL_ONES = 16'hffff;

  typedef struct packed {
    logic [MCX_DW-1:0] addr;
    logic [MCX_DW-1:0] data;
  } mcx_spi_wr_s;

  typedef struct packed {
    logic cs;
    logic mask_zero_flag;
    logic mask_ones_flag;
  } mcx_cond_s;

  typedef enum logic [1:0] {MCX_IDLE, MCX_WAITING, MCX_WRITING} mcx_state_e;
endpackage : mcx_pkg

// *** hw/mcx_wait_table.sv ***
// Wait table: five rows of condition select, edge type and destination
`timescale 1ns/1ps
module mcx_wait_table
  import mcx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load_en,
  input wire logic [2:0] load_row,
  input wire logic load_falling,
  input wire logic [3:0] load_cond_sel,
  input wire logic [MCX_PCW-1:0] load_dest,
  input wire logic [15:0] cond_in,
  input wire logic [MCX_ROWS-1:0] row_enable,
  output logic hit,
  output logic [MCX_PCW-1:0] hit_dest
);
  logic [15:0] cond_prev_r;
  logic [MCX_ROWS-1:0] row_fire;
  logic [MCX_PCW-1:0] dest_r [MCX_ROWS];

  always_ff @(posedge core_clk) begin
    if (!rst_n) cond_prev_r <= 16'h0000;
    else cond_prev_r <= cond_in;
  end

  genvar g;
  generate
    for (g = 0; g < MCX_ROWS; g++) begin : g_row
      logic [3:0] sel_r;
      logic fall_r;
      logic valid_r;
      wire logic now_w = cond_in[sel_r];
      wire logic was_w = cond_prev_r[sel_r];
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          sel_r <= 4'h0;
          fall_r <= 1'b0;
          valid_r <= 1'b0;
          dest_r[g] <= MCX_PC_RST;
        end else if (load_en && load_row == 3'(g)) begin
          sel_r <= load_cond_sel;
          fall_r <= load_falling;
          valid_r <= 1'b1;
          dest_r[g] <= load_dest;
        end
      end
      // Bit n of the enable field gates row n
      assign row_fire[g] = row_enable[g] && valid_r && (fall_r ? (was_w && !now_w) : (!was_w && now_w));
    end
  endgenerate

  // Lowest numbered row wins when several fire together
  always_comb begin
    hit = 1'b0;
    hit_dest = MCX_PC_RST;
    for (int i = MCX_ROWS - 1; i >= 0; i--) begin
      if (row_fire[i]) begin
        hit = 1'b1;
        hit_dest = dest_r[i];
      end
    end
  end
endmodule : mcx_wait_table

// *** hw/mcx_exec.sv ***
// Executor for conversion, wait, backdoor write and xor-mask instructions
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module mcx_exec
  import mcx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] alu_immediate_register,
  input wire logic spi_add_we,
  input wire logic spi_data_we,
  input wire logic [15:0] spi_wdata,
  input wire logic [15:0] cond_in,
  input wire logic [MCX_PCW-1:0] wait_load_dest,
  input wire logic [3:0] wait_load_cond_sel,
  input wire logic [2:0] alu_rd_sel,
  output logic [15:0] alu_rd_data,
  output logic [MCX_PCW-1:0] program_counter,
  output logic stall,
  output mcx_cond_s cond_flags,
  output mcx_spi_wr_s spi_wr,
  output logic spi_wr_strobe,
  output logic spi_wr_corrupt
);
  mcx_state_e state_r, state_nxt;
  logic [15:0] regs_r [MCX_NREG];
  logic [MCX_PCW-1:0] pc_r;
  mcx_cond_s cond_r;
  logic [15:0] spi_add_r;
  logic [15:0] spi_data_r;
  mcx_spi_wr_s spi_wr_r;
  logic spi_strobe_r;
  logic spi_corrupt_r;
  logic [1:0] wr_cnt_r;
  logic [MCX_ROWS-1:0] wait_en_r;

  wire logic exec_ok = instr_valid && state_r == MCX_IDLE;
  wire logic is_toint = exec_ok && (instr & MCX_MSK_TOINT) == MCX_OP_TOINT;
  wire logic is_wait = exec_ok && (instr & MCX_MSK_WAIT) == MCX_OP_WAIT;
  wire logic is_wrspi = exec_ok && (instr & MCX_MSK_WRSPI) == MCX_OP_WRSPI;
  wire logic is_xor = exec_ok && (instr & MCX_MSK_XOR) == MCX_OP_XOR;
  wire logic is_cwer = exec_ok && (instr & MCX_MSK_CWE) == MCX_OP_CWER;
  wire logic is_cwef = exec_ok && (instr & MCX_MSK_CWE) == MCX_OP_CWEF;
  wire logic is_cwe = is_cwer || is_cwef;

  wire logic [2:0] op_sel = instr[2:0];
  wire logic [15:0] operand = regs_r[op_sel];
  wire logic op_msb = operand[15];
  // Magnitude of a negative operand: fifteen-bit negation, sign bit cleared
  wire logic [14:0] mag_low = 15'(~operand[14:0] + 15'h0001);
  wire logic [15:0] mag_val = {1'b0, mag_low};
  wire logic [15:0] conv_val = op_msb ? mag_val : operand;
  wire logic sign_rst = instr[MCX_RST_BIT];
  wire logic cs_nxt = sign_rst ? op_msb : (cond_r.cs ^ op_msb);
  wire logic [15:0] xor_val = operand ^ alu_immediate_register;
  wire logic [MCX_ROWS-1:0] wait_field = instr[MCX_ROWS-1:0];

  logic tbl_hit;
  logic [MCX_PCW-1:0] tbl_dest;

  mcx_wait_table u_table (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load_en(is_cwe),
    .load_row(instr[MCX_CWE_ROW_LSB +: 3]),
    .load_falling(is_cwef),
    .load_cond_sel(wait_load_cond_sel),
    .load_dest(wait_load_dest),
    .cond_in(cond_in),
    .row_enable(wait_en_r),
    .hit(tbl_hit),
    .hit_dest(tbl_dest)
  );

  // A zero field never yields a hit, so the stall holds forever
  wire logic wait_done = state_r == MCX_WAITING && tbl_hit;
  wire logic wr_done = state_r == MCX_WRITING && wr_cnt_r == 2'(MCX_WR_CYC - 2'd1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MCX_IDLE: begin
        if (is_wait) state_nxt = MCX_WAITING;
        else if (is_wrspi) state_nxt = MCX_WRITING;
      end
      MCX_WAITING: begin
        if (tbl_hit) state_nxt = MCX_IDLE;
      end
      MCX_WRITING: begin
        if (wr_done) state_nxt = MCX_IDLE;
      end
      default: state_nxt = MCX_IDLE;
    endcase
  end

  wire logic [MCX_PCW-1:0] pc_nxt = wait_done ? tbl_dest :
                                   (exec_ok && !is_wait) ? MCX_PCW'(pc_r + 1'b1) : pc_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= MCX_IDLE;
      pc_r <= MCX_PC_RST;
      wait_en_r <= '0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      if (is_wait) wait_en_r <= wait_field;
    end
  end

  genvar g;
  generate
    for (g = 0; g < MCX_NREG; g++) begin : g_reg
      always_ff @(posedge core_clk) begin
        if (!rst_n) regs_r[g] <= MCX_REG_RST;
        else if (op_sel == 3'(g) && is_toint) regs_r[g] <= conv_val;
        else if (op_sel == 3'(g) && is_xor) regs_r[g] <= xor_val;
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cond_r <= '{cs: MCX_CS_RST, mask_zero_flag: 1'b0, mask_ones_flag: 1'b0};
    end else begin
      if (is_toint) cond_r.cs <= cs_nxt;
      if (is_xor) begin
        cond_r.mask_zero_flag <= xor_val == 16'h0000;
        cond_r.mask_ones_flag <= xor_val == MCX_ALL_ONES;
      end
    end
  end

  // Address and data registers are writable by the sequencer at any time
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      spi_add_r <= MCX_REG_RST;
      spi_data_r <= MCX_REG_RST;
    end else begin
      if (spi_add_we) spi_add_r <= spi_wdata;
      if (spi_data_we) spi_data_r <= spi_wdata;
    end
  end

  // Values are sampled at the request; a write to either register while
  // writing flags the write as dummy and inverts its data, as the hardware gives no guarantee
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_cnt_r <= 2'd0;
      spi_wr_r <= '0;
      spi_strobe_r <= 1'b0;
      spi_corrupt_r <= 1'b0;
    end else begin
      spi_strobe_r <= wr_done;
      if (is_wrspi) begin
        wr_cnt_r <= 2'd0;
        spi_wr_r <= '{addr: spi_add_r, data: spi_data_r};
        spi_corrupt_r <= 1'b0;
      end else if (state_r == MCX_WRITING) begin
        wr_cnt_r <= 2'(wr_cnt_r + 2'd1);
        if (spi_add_we || spi_data_we) begin
          spi_corrupt_r <= 1'b1;
          spi_wr_r.data <= ~spi_data_r;
        end
      end
    end
  end

  assign program_counter = pc_r;
  assign stall = state_r != MCX_IDLE;
  assign cond_flags = cond_r;
  assign spi_wr = spi_wr_r;
  assign spi_wr_strobe = spi_strobe_r;
  assign spi_wr_corrupt = spi_corrupt_r;
  assign alu_rd_data = regs_r[alu_rd_sel];
endmodule : mcx_exec

// *** testbench/mcx_exec_props.sv ***
// Checker for the misc instruction executor
`timescale 1ns/1ps
module mcx_exec_props
  import mcx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] alu_immediate_register,
  input wire logic [2:0] alu_rd_sel,
  input wire logic [15:0] alu_rd_data,
  input wire logic [MCX_PCW-1:0] program_counter,
  input wire logic stall,
  input wire mcx_cond_s cond_flags,
  input wire logic spi_wr_strobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Operand checks only when the read port shows the operand register
  wire tk = instr_valid && !stall;
  wire sel_ok = alu_rd_sel == instr[2:0];
  wire ti = tk && sel_ok && (instr & MCX_MSK_TOINT) == MCX_OP_TOINT;
  wire xr = tk && sel_ok && (instr & MCX_MSK_XOR) == MCX_OP_XOR;
  wire [15:0] xv = alu_rd_data ^ alu_immediate_register;
  wr_len_a: assert property (tk && instr == MCX_OP_WRSPI |=> stall ##1 stall ##1 !stall && spi_wr_strobe)
    else $error("backdoor write timing wrong");
  cs_xor_a: assert property (ti && !instr[3] |=> cond_flags.cs == ($past(cond_flags.cs) ^ $past(alu_rd_data[15])))
    else $error("sign bit not toggled");
  cs_load_a: assert property (ti && instr[3] |=> cond_flags.cs == $past(alu_rd_data[15]))
    else $error("sign bit not loaded");
  xor_back_a: assert property (xr |=> alu_rd_data == $past(xv))
    else $error("xor result wrong");
  mask_zero_a: assert property (xr |=> cond_flags.mask_zero_flag == ($past(xv) == 16'h0000))
    else $error("zero flag wrong");
  mask_ones_a: assert property (xr |=> cond_flags.mask_ones_flag == ($past(xv) == 16'hffff))
    else $error("ones flag wrong");
  pc_hold_a: assert property (stall ##1 stall |-> $stable(program_counter))
    else $error("counter moved while stalled");
  wait_zero_a: assert property (tk && instr == MCX_OP_WAIT |=> stall [*8])
    else $error("empty wait left stall");
  cover property (xr ##1 cond_flags.mask_zero_flag);
  cover property (stall ##1 !stall);
  cover property (spi_wr_strobe);
endmodule : mcx_exec_props

// *** testbench/tb.sv ***
// Self-checking bench for the misc instruction executor
`timescale 1ns/1ps
module tb;
  import mcx_pkg::*;
  logic core_clk, rst_n, instr_valid, spi_add_we, spi_data_we, stall, spi_wr_strobe, spi_wr_corrupt, cs;
  logic [15:0] instr, alu_immediate_register, spi_wdata, cond_in, alu_rd_data, v, e;
  logic [MCX_PCW-1:0] wait_load_dest, program_counter, pcm;
  logic [MCX_PCW-1:0] dst [5];
  logic [15:0] m [8];
  logic [3:0] wait_load_cond_sel;
  logic [2:0] alu_rd_sel;
  mcx_cond_s cond_flags;
  mcx_spi_wr_s spi_wr;
  int miscompares, total_checks, cyc, r;
  mcx_exec dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .alu_immediate_register(alu_immediate_register),
    .spi_add_we(spi_add_we),
    .spi_data_we(spi_data_we),
    .spi_wdata(spi_wdata),
    .cond_in(cond_in),
    .wait_load_dest(wait_load_dest),
    .wait_load_cond_sel(wait_load_cond_sel),
    .alu_rd_sel(alu_rd_sel),
    .alu_rd_data(alu_rd_data),
    .program_counter(program_counter),
    .stall(stall),
    .cond_flags(cond_flags),
    .spi_wr(spi_wr),
    .spi_wr_strobe(spi_wr_strobe),
    .spi_wr_corrupt(spi_wr_corrupt)
  );
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  // Issue one word; returns just after the edge that takes it
  task automatic op(input logic [15:0] w);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= w;
    alu_rd_sel <= w[2:0];
    tick();
    instr_valid <= 1'b0;
    pcm = pcm + 10'h001;
  endtask : op
  task automatic spi(input logic a, input logic [15:0] d);
    @(posedge core_clk);
    spi_add_we <= a;
    spi_data_we <= !a;
    spi_wdata <= d;
    @(posedge core_clk);
    {spi_add_we, spi_data_we} <= 2'b00;
  endtask : spi
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    {instr_valid, spi_add_we, spi_data_we, instr, alu_immediate_register, spi_wdata, cond_in} = '0;
    {wait_load_dest, wait_load_cond_sel, alu_rd_sel, cs, pcm} = '0;
    m = '{default: 16'h0000};
    rst_n = 1'b0;
    void'($urandom(32'h6a9bc51a));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (60) begin
      r = $urandom % 8;
      case ($urandom % 4)
        0: v = m[r];
        1: v = ~m[r];
        default: v = $urandom;
      endcase
      alu_immediate_register <= v;
      if ($urandom % 3 == 0) begin
        cs = v[3] ? m[r][15] : cs ^ m[r][15];
        m[r] = m[r][15] ? {1'b0, 15'(-m[r][14:0])} : m[r];
        op(MCX_OP_TOINT | {12'h000, v[3], r[2:0]});
      end else begin
        m[r] = m[r] ^ v;
        op(MCX_OP_XOR | {13'h0000, r[2:0]});
        chk("mzero", cond_flags.mask_zero_flag, m[r] == 16'h0000);
        chk("mones", cond_flags.mask_ones_flag, m[r] == MCX_ALL_ONES);
      end
      chk("reg", alu_rd_data, m[r]);
      chk("cs", cond_flags.cs, cs);
      chk("pc", program_counter, pcm);
    end
    for (int k = 0; k < 5; k++) begin
      dst[k] = 10'($urandom);
      wait_load_dest <= dst[k];
      wait_load_cond_sel <= 4'(k);
      op((k % 2 ? MCX_OP_CWEF : MCX_OP_CWER) | 16'(k << 4));
    end
    // Odd rows wait for a falling edge, so their line idles high
    for (int k = 0; k < 5; k++) begin
      cond_in <= k % 2 ? 16'hffff : 16'h0000;
      repeat (2) tick();
      op(MCX_OP_WAIT | 16'(1 << k));
      cond_in[(k + 1) % 5] <= ~cond_in[(k + 1) % 5];
      repeat (3) tick();
      chk("hold", stall, 1'b1);
      cond_in[k] <= ~cond_in[k];
      for (r = 0; r < 6 && stall !== 1'b0; r++) tick();
      pcm = dst[k];
      chk("jump", {stall, program_counter}, {1'b0, pcm});
    end
    // All rows enabled, two lines rise together: the lowest row must win
    cond_in <= 16'h0000;
    repeat (2) tick();
    op(MCX_OP_WAIT | 16'h001f);
    cond_in <= 16'h0014;
    for (r = 0; r < 6 && stall !== 1'b0; r++) tick();
    pcm = dst[2];
    chk("multi", {stall, program_counter}, {1'b0, pcm});
    for (int k = 0; k < 2; k++) begin
      v = $urandom;
      e = $urandom;
      spi(1'b1, v);
      spi(1'b0, e);
      op(MCX_OP_WRSPI);
      spi_data_we <= k[0];
      spi_wdata <= ~e;
      tick();
      spi_data_we <= 1'b0;
      for (r = 0; r < 4 && spi_wr_strobe !== 1'b1; r++) tick();
      chk("strobe", spi_wr_strobe, 1'b1);
      if (k == 0) chk("spiwr", spi_wr, {v, e});
      else chk("spiadd", spi_wr.addr, v);
      chk("corrupt", spi_wr_corrupt, k[0]);
      chk("pc", program_counter, pcm);
      tick();
      chk("strobe_end", spi_wr_strobe, 1'b0);
    end
    op(MCX_OP_WAIT);
    repeat (20) begin
      cond_in <= $urandom;
      tick();
    end
    chk("stuck", stall, 1'b1);
    rst_n <= 1'b0;
    repeat (2) tick();
    rst_n <= 1'b1;
    tick();
    chk("rst", {stall, program_counter, alu_rd_data, cond_flags, spi_wr_strobe, spi_wr_corrupt}, '0);
    end_of_test();
  end
endmodule : tb

bind mcx_exec mcx_exec_props props_u (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .instr_valid(instr_valid),
  .instr(instr),
  .alu_immediate_register(alu_immediate_register),
  .alu_rd_sel(alu_rd_sel),
  .alu_rd_data(alu_rd_data),
  .program_counter(program_counter),
  .stall(stall),
  .cond_flags(cond_flags),
  .spi_wr_strobe(spi_wr_strobe)
);
